// file: hdl/host_to_card_mm_chan_ctrl.sv
// Control, status and finished-descriptor tally of one host-to-card MM channel
// Contract
// - Control bit 0 starts engine; clearing it stops after current descriptor
// - Control bit 27 set suppresses stream writeback; clear keeps writeback on
// - Control bit 26 set writes back tally on finishing a Completed descriptor
// - Control bit 25 set holds read address constant; read channel only
// - Error enable field active only when all ones; then logs and halts
// - Control bits 6 to 1 permit recording of their matching status flags
// - Each enabled status condition raises an interrupt event
// - Set alias write sets control bits 26:0 written as one
// - Clear alias write clears control bits 26:0 written as one
// - Fetch fault field 23:19 records fetch failures per bit
// - Write error field 18:14 records slave and decode errors only
// - Read error field 13:9 uses the fetch fault encoding
// - Setting the run bit zeroes every sticky flag and error field, except bits set in that same cycle
// - Bit 6 sets once engine goes idle after run was cleared
// - Bit 5 sets on descriptor length not a stream width multiple
// - Bit 4 sets and engine stops on invalid descriptor signature
// - Bit 3 sets on misaligned source and destination addresses
// - Bit 2 sets after finishing a descriptor with COMPLETE flag
// - Bit 1 sets after finishing a descriptor with STOP flag
// - Status bit 0 is read-only busy indication
// - Clear-on-read alias returns bits 23:1 and clears them, with live busy in bit 0
// - 32-bit tally counts finished descriptors; zeroed on run rising edge
`timescale 1ns/100ps
`default_nettype none
module host_to_card_mm_chan_ctrl
   import host_to_card_pkg::*;
#(
   parameter int TALLY_W = 32
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [APB_AW-1:0] PADDR,
   input wire logic [DATA_W-1:0] PWDATA,
   output logic PREADY,
   output logic [DATA_W-1:0] PRDATA,
   output logic PSLVERR,
   input wire logic ENG_BUSY,
   input wire logic DESC_DONE,
   input wire logic DESC_COMPLETE_FLAG,
   input wire logic DESC_STOP_FLAG,
   input wire logic MAGIC_BAD,
   input wire logic LENGTH_BAD,
   input wire logic ALIGN_BAD,
   input wire logic [ERR_W-1:0] FETCH_FAULT,
   input wire logic [ERR_W-1:0] WRITE_FAULT,
   input wire logic [ERR_W-1:0] READ_FAULT,
   output logic ENGINE_GO,
   output logic ARADDR_FIXED,
   output logic STREAM_WRITEBACK_OFF,
   output logic TALLY_WRITEBACK,
   output logic IRQ_EVENT
);

   typedef struct packed {
      logic [31:0] ctrl;
      logic stopping;
      logic halted;
      logic go;
      logic [TALLY_W-1:0] tally;
      logic pready;
      logic [DATA_W-1:0] prdata;
      logic pslverr;
      logic tally_wb;
      logic irq;
   } chan_state_s;

   chan_state_s s_q;
   chan_state_s s_d;
   logic [31:0] stat_set;
   logic [31:0] stat_clr;
   logic stat_clr_all;
   logic [FLAG_W-1:0] flags;
   logic [31:0] status_word;
   logic run_rise;
   logic halt_evt;
   logic idle_evt;
   logic setup;
   logic done;
   reg_sel_e sel;

   // ==========================================================
   // Address decode, shared by setup and completion phases
   function automatic reg_sel_e reg_decode(input logic [APB_AW-1:0] a);
      reg_sel_e r;
      r = SEL_NONE;
      if (a == OFS_CONTROL) begin
         r = SEL_CTRL;
      end else if (a == OFS_CONTROL_SET) begin
         r = SEL_CSET;
      end else if (a == OFS_CONTROL_CLEAR) begin
         r = SEL_CCLR;
      end else if (a == OFS_STATUS) begin
         r = SEL_STAT;
      end else if (a == OFS_STATUS_RC) begin
         r = SEL_SRC;
      end else if (a == OFS_TALLY) begin
         r = SEL_TALLY;
      end
      return r;
   endfunction

   // An error field counts as enabled only when every bit is written one
   function automatic logic err_enabled(input logic [ERR_W-1:0] f);
      return f == ERR_ENABLE_ALL;
   endfunction

   // ==========================================================
   // Status flag storage
   sticky_flag_bank #(
      .W(FLAG_W)
   ) u_flags (
      .clk(CLK),
      .rst(RST),
      .set_bits(stat_set[FLAG_HI:FLAG_LO]),
      .clr_bits(stat_clr[FLAG_HI:FLAG_LO]),
      .clr_all(stat_clr_all),
      .flags(flags)
   );

   // Busy is live; sticky flags are masked so reserved bits read zero
   assign status_word = ({8'h00, flags, 1'b0} & STATUS_MASK) | {31'h0, ENG_BUSY};

   // ==========================================================
   // Next state
   always_comb begin
      s_d = s_q;
      stat_set = '0;
      stat_clr = '0;
      setup = PSEL & ~PENABLE;
      done = PSEL & PENABLE & s_q.pready;
      sel = reg_decode(PADDR);

      // Zero wait state: data and ready are prepared during setup
      s_d.pready = setup;
      s_d.pslverr = setup & (sel == SEL_NONE);
      if (setup) begin
         s_d.prdata = '0;
         if (sel == SEL_CTRL || sel == SEL_CSET || sel == SEL_CCLR) begin
            s_d.prdata = s_q.ctrl;
         end else if (sel == SEL_STAT || sel == SEL_SRC) begin
            s_d.prdata = status_word;
         end else if (sel == SEL_TALLY) begin
            s_d.prdata = DATA_W'(s_q.tally);
         end
      end

      if (done && PWRITE) begin
         if (sel == SEL_CTRL) begin
            s_d.ctrl = PWDATA & CONTROL_MASK;
         end else if (sel == SEL_CSET) begin
            s_d.ctrl = s_q.ctrl | (PWDATA & ALIAS_MASK & CONTROL_MASK);
         end else if (sel == SEL_CCLR) begin
            s_d.ctrl = s_q.ctrl & ~(PWDATA & ALIAS_MASK);
         end else if (sel == SEL_STAT) begin
            stat_clr = PWDATA & STATUS_MASK;
         end
      end
      // Only the bits actually returned are cleared, so a late event survives
      if (done && !PWRITE && sel == SEL_SRC) begin
         stat_clr = s_q.prdata & STATUS_MASK;
      end

      run_rise = ~s_q.ctrl[POS_RUN] & s_d.ctrl[POS_RUN];
      stat_clr_all = run_rise;

      // Error fields log and halt only when fully enabled
      if (err_enabled(s_q.ctrl[POS_FETCH_ERR +: ERR_W])) begin
         stat_set[POS_FETCH_ERR +: ERR_W] = FETCH_FAULT;
      end
      if (err_enabled(s_q.ctrl[POS_WRITE_ERR +: ERR_W])) begin
         stat_set[POS_WRITE_ERR +: ERR_W] = WRITE_FAULT & WRITE_ERR_VALID;
      end
      if (err_enabled(s_q.ctrl[POS_READ_ERR +: ERR_W])) begin
         stat_set[POS_READ_ERR +: ERR_W] = READ_FAULT;
      end
      stat_set[POS_LENGTH] = LENGTH_BAD & s_q.ctrl[POS_LENGTH];
      stat_set[POS_MAGIC] = MAGIC_BAD & s_q.ctrl[POS_MAGIC];
      stat_set[POS_ALIGN] = ALIGN_BAD & s_q.ctrl[POS_ALIGN];
      stat_set[POS_DESC_DONE] = DESC_DONE & DESC_COMPLETE_FLAG & s_q.ctrl[POS_DESC_DONE];
      stat_set[POS_DESC_STOP] = DESC_DONE & DESC_STOP_FLAG & s_q.ctrl[POS_DESC_STOP];

      halt_evt = (stat_set[POS_FETCH_ERR +: ERR_W] != '0) | (stat_set[POS_WRITE_ERR +: ERR_W] != '0)
         | (stat_set[POS_READ_ERR +: ERR_W] != '0) | stat_set[POS_MAGIC];

      // Idle after a stop request: engine quiet and no longer told to go
      idle_evt = s_q.stopping & ~ENG_BUSY & ~s_q.go & ~run_rise;
      stat_set[POS_IDLE] = idle_evt & s_q.ctrl[POS_IDLE];

      // A fault in the cycle of the run edge still halts, as its flag survives too
      if (run_rise) begin
         s_d.halted = halt_evt;
         s_d.stopping = 1'b0;
      end else begin
         s_d.halted = s_q.halted | halt_evt;
         if (s_q.ctrl[POS_RUN] && !s_d.ctrl[POS_RUN]) begin
            s_d.stopping = 1'b1;
         end else if (idle_evt) begin
            s_d.stopping = 1'b0;
         end
      end

      // After run drops, go holds until the descriptor in flight is finished
      s_d.go = (s_d.ctrl[POS_RUN] & ~s_d.halted)
         | (s_q.go & ENG_BUSY & ~DESC_DONE & ~s_d.halted);

      if (run_rise) begin
         s_d.tally = TALLY_W'(TALLY_RESET);
      end else if (DESC_DONE) begin
         s_d.tally = s_q.tally + TALLY_W'(1);
      end

      s_d.tally_wb = DESC_DONE & DESC_COMPLETE_FLAG & s_q.ctrl[POS_POLL_WB];
      s_d.irq = (stat_set != '0);
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // Outputs, each straight from state
   assign PREADY = s_q.pready;
   assign PRDATA = s_q.prdata;
   assign PSLVERR = s_q.pslverr;
   assign ENGINE_GO = s_q.go;
   assign ARADDR_FIXED = s_q.ctrl[POS_FIXED_ADDR];
   assign STREAM_WRITEBACK_OFF = s_q.ctrl[POS_WB_OFF];
   assign TALLY_WRITEBACK = s_q.tally_wb;
   assign IRQ_EVENT = s_q.irq;

   // ==========================================================
   // Checks
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);

   apb_ready_a: assert property (
      (PSEL && !PENABLE) |=> PREADY ##1 !PREADY)
      else $error("ready not one cycle after setup");

   tally_start_a: assert property (
      $rose(s_q.ctrl[POS_RUN]) |-> (s_q.tally == '0))
      else $error("tally not zero after run set");

   tally_step_a: assert property (
      (DESC_DONE && !run_rise) |=> (s_q.tally == $past(s_q.tally) + TALLY_W'(1)))
      else $error("tally missed a finished descriptor");

   fetch_halt_a: assert property (
      ((FETCH_FAULT != '0) && err_enabled(s_q.ctrl[POS_FETCH_ERR +: ERR_W]) && !run_rise)
      |=> !ENGINE_GO && (flags[POS_FETCH_ERR-FLAG_LO +: ERR_W] != '0))
      else $error("enabled fetch fault did not log and halt");

   stop_finish_a: assert property (
      (!s_d.ctrl[POS_RUN] && ENGINE_GO && ENG_BUSY && !DESC_DONE && !halt_evt && !s_q.halted)
      |=> ENGINE_GO)
      else $error("go dropped inside a descriptor");

   set_alias_a: assert property (
      (done && PWRITE && sel == SEL_CSET)
      |=> (s_q.ctrl[26:0] == (($past(s_q.ctrl[26:0]) | $past(PWDATA[26:0])) & CONTROL_MASK[26:0])))
      else $error("set alias did not merge bits");

   read_clear_a: assert property (
      (done && !PWRITE && sel == SEL_SRC && stat_set == '0)
      |=> ((flags & $past(s_q.prdata[FLAG_HI:FLAG_LO])) == '0))
      else $error("clear-on-read left a flag set");

   poll_wb_a: assert property (
      (DESC_DONE && DESC_COMPLETE_FLAG && s_q.ctrl[POS_POLL_WB]) |=> TALLY_WRITEBACK)
      else $error("tally writeback request missing");

   idle_flag_a: assert property (
      (idle_evt && s_q.ctrl[POS_IDLE]) |=> flags[POS_IDLE-FLAG_LO])
      else $error("idle-stop flag not set");

endmodule
`default_nettype wire

// file: hdl/host_to_card_pkg.sv
// Shared constants for the host-to-card channel control and status block
package host_to_card_pkg;

   // ==========================================================
   // Bus geometry and register offsets (byte addresses)
   localparam int APB_AW = 8;
   localparam int DATA_W = 32;
   localparam logic [7:0] OFS_CONTROL = 8'h04;
   localparam logic [7:0] OFS_CONTROL_SET = 8'h08;
   localparam logic [7:0] OFS_CONTROL_CLEAR = 8'h0C;
   localparam logic [7:0] OFS_STATUS = 8'h40;
   localparam logic [7:0] OFS_STATUS_RC = 8'h44;
   localparam logic [7:0] OFS_TALLY = 8'h48;

   // ==========================================================
   // Bit positions of control and status words; 25 to 27 are control only
   localparam int POS_RUN = 0;
   localparam int POS_DESC_STOP = 1;
   localparam int POS_DESC_DONE = 2;
   localparam int POS_ALIGN = 3;
   localparam int POS_MAGIC = 4;
   localparam int POS_LENGTH = 5;
   localparam int POS_IDLE = 6;
   localparam int POS_READ_ERR = 9;
   localparam int POS_WRITE_ERR = 14;
   localparam int POS_FETCH_ERR = 19;
   localparam int POS_FIXED_ADDR = 25;
   localparam int POS_POLL_WB = 26;
   localparam int POS_WB_OFF = 27;
   localparam int ERR_W = 5;
   localparam int FLAG_LO = 1;
   localparam int FLAG_HI = 23;
   localparam int FLAG_W = FLAG_HI - FLAG_LO + 1;

   // ==========================================================
   // Masks and reset values
   localparam logic [4:0] ERR_ENABLE_ALL = 5'h1F;
   localparam logic [4:0] WRITE_ERR_VALID = 5'h03;
   localparam logic [31:0] CONTROL_MASK = 32'h0EFF_FE7F;
   localparam logic [31:0] ALIAS_MASK = 32'h07FF_FFFF;
   localparam logic [31:0] STATUS_MASK = 32'h00FF_FE7E;
   localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
   localparam logic [31:0] TALLY_RESET = 32'h0000_0000;

   // Register select codes, one-hot
   typedef enum logic [6:0] {
      SEL_NONE = 7'b0000001,
      SEL_CTRL = 7'b0000010,
      SEL_CSET = 7'b0000100,
      SEL_CCLR = 7'b0001000,
      SEL_STAT = 7'b0010000,
      SEL_SRC = 7'b0100000,
      SEL_TALLY = 7'b1000000
   } reg_sel_e;

endpackage

// file: hdl/sticky_flag_bank.sv
// Bank of sticky status flags with set-over-clear priority
`timescale 1ns/100ps
`default_nettype none
module sticky_flag_bank #(
   parameter int W = 23
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] set_bits,
   input wire logic [W-1:0] clr_bits,
   input wire logic clr_all,
   output logic [W-1:0] flags
);

   typedef struct packed {
      logic [W-1:0] flags;
   } bank_state_s;

   bank_state_s s_q;
   bank_state_s s_d;

   // ==========================================================
   // Next state: a clear never swallows an event of the same cycle
   always_comb begin
      s_d = s_q;
      s_d.flags = (s_q.flags & ~clr_bits & ~{W{clr_all}}) | set_bits;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign flags = s_q.flags;

   // ==========================================================
   // Checks
   set_wins_a: assert property (@(posedge clk) disable iff (rst)
      (set_bits != '0) |=> ((flags & $past(set_bits)) == $past(set_bits)))
      else $error("event lost against a clear of the same cycle");

endmodule
`default_nettype wire

// file: verif/engine_stub.sv
// Behavioural engine model that feeds descriptor events to the channel block
`timescale 1ns/100ps
`default_nettype none
module engine_stub (
   input wire logic clk,
   input wire logic go,
   output logic busy,
   output logic done,
   output logic cflag,
   output logic sflag,
   output logic [17:0] ev
);
   initial begin
      busy = 1'b0;
      done = 1'b0;
      cflag = 1'b0;
      sflag = 1'b0;
      ev = '0;
   end

   // ==========
   // One descriptor; a stop request never cuts it short
   task automatic desc(input logic c, input logic s);
      while (go !== 1'b1) @(posedge clk);
      @(posedge clk);
      busy <= 1'b1;
      repeat (3) @(posedge clk);
      done <= 1'b1;
      cflag <= c;
      sflag <= s;
      @(posedge clk);
      done <= 1'b0;
      cflag <= 1'b0;
      sflag <= 1'b0;
      busy <= 1'b0;
   endtask

   // ==========
   // Fault and check pulses, one cycle wide
   task automatic inject(input logic [17:0] v);
      @(posedge clk);
      ev <= v;
      @(posedge clk);
      ev <= '0;
   endtask
endmodule
`default_nettype wire

// file: verif/test_host_to_card_mm_chan_ctrl.sv
// Self-checking bench for the host-to-card channel control block
`timescale 1ns/100ps
`default_nettype none
module test_host_to_card_mm_chan_ctrl import host_to_card_pkg::*;;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = '0;
   logic [31:0] pwdata = '0;
   wire logic pready, pslverr, go, afix, wboff, twb, irq, busy, done, cf, sf;
   wire logic [31:0] prdata;
   wire logic [17:0] ev;
   int n_mismatch = 0;
   int checked = 0;
   int n_twb = 0;
   int n_irq = 0;

   always #2.5 clk = ~clk;

   host_to_card_mm_chan_ctrl #(.TALLY_W(32)) i_dut (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr),
      .ENG_BUSY(busy), .DESC_DONE(done), .DESC_COMPLETE_FLAG(cf), .DESC_STOP_FLAG(sf), .MAGIC_BAD(ev[17]),
      .LENGTH_BAD(ev[16]), .ALIGN_BAD(ev[15]), .FETCH_FAULT(ev[14:10]), .WRITE_FAULT(ev[9:5]),
      .READ_FAULT(ev[4:0]), .ENGINE_GO(go), .ARADDR_FIXED(afix), .STREAM_WRITEBACK_OFF(wboff),
      .TALLY_WRITEBACK(twb), .IRQ_EVENT(irq));

   engine_stub i_eng (.clk(clk), .go(go), .busy(busy), .done(done), .cflag(cf), .sflag(sf), .ev(ev));

   always @(posedge clk) begin
      if (twb === 1'b1) n_twb++;
      if (irq === 1'b1) n_irq++;
   end

   // ==========
   // Bus and compare helpers
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, '0, r, e);
      chk(r, exp);
   endtask

   task automatic rd_err(input logic w, input logic [7:0] a);
      logic [31:0] r;
      logic e;
      apb(w, a, 32'hFFFF_FFFF, r, e);
      chk({31'h0, e}, 32'h1);
      if (w == 1'b0) chk(r, 32'h0);
   endtask

   // ==========
   // Scenarios
   task automatic t_reset;
      chk({27'h0, go, afix, wboff, twb, irq}, 32'h0);
      rd_err(1'b1, 8'h05);
      rd_err(1'b0, 8'h10);
      rd(OFS_CONTROL, 32'h0);
      rd(OFS_STATUS, 32'h0);
      rd(OFS_TALLY, 32'h0);
      $display("test reset finished");
   endtask

   task automatic t_alias;
      wr(OFS_CONTROL, 32'hFFFF_FFFE);
      rd(OFS_CONTROL, 32'h0EFF_FE7E);
      wr(OFS_CONTROL_CLEAR, 32'hFFFF_FFFF);
      rd(OFS_CONTROL, 32'h0800_0000);
      wr(OFS_CONTROL_SET, 32'h0200_0000);
      rd(OFS_CONTROL_SET, 32'h0A00_0000);
      @(negedge clk);
      chk({30'h0, afix, wboff}, 32'h3);
      wr(OFS_CONTROL, 32'h0);
      @(negedge clk);
      chk({30'h0, afix, wboff}, 32'h0);
      $display("test alias finished");
   endtask

   task automatic t_desc;
      int tw;
      int iq;
      wr(OFS_CONTROL, 32'h0400_0007);
      tw = n_twb;
      iq = n_irq;
      fork
         i_eng.desc(1'b1, 1'b1);
         begin
            repeat (2) @(posedge clk);
            rd(OFS_STATUS, 32'h1);
         end
      join
      repeat (2) @(posedge clk);
      rd(OFS_STATUS, 32'h6);
      rd(OFS_TALLY, 32'h1);
      chk(n_twb - tw, 32'h1);
      chk(n_irq - iq, 32'h1);
      i_eng.desc(1'b0, 1'b0);
      repeat (2) @(posedge clk);
      rd(OFS_TALLY, 32'h2);
      chk(n_twb - tw, 32'h1);
      $display("test descriptor finished");
   endtask

   task automatic t_clear;
      wr(OFS_STATUS, 32'h4);
      rd(OFS_STATUS, 32'h2);
      rd(OFS_STATUS_RC, 32'h2);
      rd(OFS_STATUS, 32'h0);
      i_eng.desc(1'b1, 1'b0);
      repeat (2) @(posedge clk);
      wr(OFS_CONTROL, 32'h0400_0006);
      wr(OFS_CONTROL_SET, 32'h1);
      rd(OFS_STATUS, 32'h0);
      rd(OFS_TALLY, 32'h0);
      $display("test clear finished");
   endtask

   task automatic t_err;
      wr(OFS_CONTROL, 32'h0);
      wr(OFS_CONTROL, 32'h00FF_FE01);
      i_eng.inject(18'h057EA);
      repeat (2) @(posedge clk);
      rd(OFS_STATUS, 32'h00A8_D400);
      @(negedge clk);
      chk({31'h0, go}, 32'h0);
      wr(OFS_CONTROL, 32'h0);
      wr(OFS_CONTROL, 32'h007F_FE01);
      i_eng.inject(18'h07C80);
      repeat (2) @(posedge clk);
      rd(OFS_STATUS, 32'h0000_0000);
      @(negedge clk);
      chk({31'h0, go}, 32'h1);
      $display("test errors finished");
   endtask

   task automatic t_flags;
      wr(OFS_CONTROL, 32'h0);
      wr(OFS_CONTROL, 32'h39);
      i_eng.inject(18'h38000);
      repeat (2) @(posedge clk);
      rd(OFS_STATUS, 32'h38);
      @(negedge clk);
      chk({31'h0, go}, 32'h0);
      wr(OFS_CONTROL, 32'h0);
      wr(OFS_CONTROL, 32'h1);
      i_eng.inject(18'h38000);
      repeat (2) @(posedge clk);
      rd(OFS_STATUS, 32'h0);
      $display("test flags finished");
   endtask

   task automatic t_stop;
      wr(OFS_CONTROL, 32'h0);
      wr(OFS_CONTROL, 32'h41);
      fork
         i_eng.desc(1'b0, 1'b0);
         begin
            wr(OFS_CONTROL, 32'h40);
            @(posedge clk);
            @(negedge clk);
            chk({31'h0, go}, 32'h1);
         end
      join
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk({31'h0, go}, 32'h0);
      rd(OFS_STATUS, 32'h40);
      $display("test stop finished");
   endtask

   // ==========
   // Verdict
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset;
      t_alias;
      t_desc;
      t_clear;
      t_err;
      t_flags;
      t_stop;
      end_sim;
   end

   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      end_sim;
   end
endmodule
`default_nettype wire
